// [design/fsc_pkg.sv]
// Package for the fan speed channel control block.
// Holds field positions, reset codes and timing counts; no module assumptions.
package fsc_pkg;
   // Dynamics setting fields
   localparam int RATE_LSB = 2;
   localparam int RATE_MSB = 4;
   localparam int RANGE_LSB = 5;
   localparam int RANGE_MSB = 7;
   // Configuration bits
   localparam int CFG_MODE_BIT = 7;
   localparam int CFG_SPEED_PULSE_INPUT_EN_BIT = 6;
   // Widths
   localparam int DRIVE_W = 9;
   localparam int COUNT_W = 11;
   // Codes
   localparam logic [8:0] DRIVE_ZERO = 9'h000;
   localparam logic [8:0] DRIVE_OPEN = 9'h180;
   localparam logic [8:0] DRIVE_FULL = 9'h1FF;
   localparam logic [10:0] COUNT_FULL = 11'h7FF;
   localparam logic [7:0] DYN_RESET = 8'h3C;
   // Timing: measurement clock 8192 Hz from 25 MHz system clock
   localparam int CLK_HZ = 25000000;
   localparam int MEAS_HZ = 8192;
   localparam int MEAS_DIV = CLK_HZ / MEAS_HZ;
   // Rate step base: cycles between drive steps for rate code 0
   localparam int RATE_BASE_CYC = 1024;
   // Startup select pin encodings
   localparam logic [1:0] START_GND = 2'h0;
   localparam logic [1:0] START_OPEN = 2'h1;
   localparam logic [1:0] START_VCC = 2'h2;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_COUNT = 2'b10
   } fsc_meas_t;
endpackage : fsc_pkg

// [design/fsc_speed_pulse_input_meter.sv]
// Tachometer period meter.
// Assumes pulse input already synchronised and the 8192 tick on the same clock.
`timescale 1ns/1ps
module fsc_speed_pulse_input_meter #(
   parameter int COUNT_W = 11
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Control
   input wire logic enable,
   input wire logic tick,
   input wire logic [2:0] range_code,
   input wire logic pulse_sync,
   // Result
   output logic [COUNT_W-1:0] count,
   output logic done
);
   initial
   begin
      if (COUNT_W < 2 || COUNT_W > 16)
         $error("fsc_speed_pulse_input_meter: COUNT_W out of range");
   end

   fsc_pkg::fsc_meas_t st_r;
   logic pulse_d_r;
   logic [7:0] edges_r;
   logic [COUNT_W-1:0] acc_r;
   logic rise;
   logic [7:0] periods;

   assign rise = pulse_sync & ~pulse_d_r;
   // Periods per measurement doubles per range step
   assign periods = 8'h01 << range_code;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pulse_d_r <= 1'b1;
      else if (ce)
         pulse_d_r <= pulse_sync;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= fsc_pkg::ST_IDLE;
         edges_r <= 8'h00;
         acc_r <= '0;
         count <= '0;
         done <= 1'b0;
      end
      else if (ce)
      begin
         done <= 1'b0;
         case (st_r)
            fsc_pkg::ST_IDLE:
               if (enable)
                  st_r <= fsc_pkg::ST_WAIT;
            fsc_pkg::ST_WAIT:
               if (!enable)
                  st_r <= fsc_pkg::ST_IDLE;
               else if (rise)
               begin
                  st_r <= fsc_pkg::ST_COUNT;
                  edges_r <= 8'h00;
                  acc_r <= '0;
               end
            fsc_pkg::ST_COUNT:
            begin
               // Saturate so a stalled fan reads full scale
               if (tick && acc_r != {COUNT_W{1'b1}})
                  acc_r <= acc_r + 1'b1;
               if (!enable)
                  st_r <= fsc_pkg::ST_IDLE;
               else if (rise)
               begin
                  // Range change mid-measurement must not overshoot the end
                  if (edges_r + 8'h01 >= periods)
                  begin
                     count <= acc_r;
                     done <= 1'b1;
                     edges_r <= 8'h00;
                     acc_r <= '0;
                  end
                  else
                     edges_r <= edges_r + 8'h01;
               end
               else if (acc_r == {COUNT_W{1'b1}})
               begin
                  // No pulses: report full scale and restart
                  count <= acc_r;
                  done <= 1'b1;
                  st_r <= fsc_pkg::ST_WAIT;
               end
            end
            default:
               st_r <= fsc_pkg::ST_IDLE;
         endcase
      end
   end
endmodule : fsc_speed_pulse_input_meter

// [design/fsc_channel.sv]
// One fan speed channel: drive code, slew limiting, speed loop and fault.
// Assumes host writes arrive as same-clock strobes; pins are asynchronous.
`timescale 1ns/1ps
module fsc_channel #(
   parameter int RATE_BASE = fsc_pkg::RATE_BASE_CYC,
   parameter int MEAS_DIV = fsc_pkg::MEAS_DIV
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Host writes
   input wire logic [7:0] cfg_wdata,
   input wire logic cfg_we,
   input wire logic [7:0] dyn_wdata,
   input wire logic dyn_we,
   input wire logic [8:0] drive_wdata,
   input wire logic drive_we,
   input wire logic [10:0] target_speed_count_wdata,
   input wire logic target_speed_count_we,
   input wire logic fault_clr,
   // Pins
   input wire logic speed_pulse_input,
   input wire logic [1:0] startup_select,
   // Status and drive
   output logic [8:0] drive_level,
   output logic [8:0] target_drive,
   output logic [10:0] measured_count,
   output logic [7:0] cfg_q,
   output logic [7:0] dyn_q,
   output logic fan_fault
);
   initial
   begin
      if (RATE_BASE < 1 || MEAS_DIV < 2)
         $error("fsc_channel: bad timing parameter");
   end

   logic rst_s1_r, rst_s2_r, srst_n;
   logic pulse_s1_r, pulse_s2_r;
   logic [1:0] sel_s1_r, sel_s2_r;
   logic strap_done_r;
   logic [1:0] strap_wait_r;
   logic [7:0] cfg_r, dyn_r;
   logic [8:0] tgt_drive_r, drive_r;
   logic [10:0] tgt_cnt_r;
   logic [31:0] div_r, slew_r;
   logic tick;
   logic [10:0] meas;
   logic meas_done;
   logic speed_mode, speed_pulse_input_en;
   logic [31:0] slew_limit;
   logic fault_r;

   assign speed_mode = cfg_r[fsc_pkg::CFG_MODE_BIT];
   assign speed_pulse_input_en = cfg_r[fsc_pkg::CFG_SPEED_PULSE_INPUT_EN_BIT];

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign srst_n = rst_s2_r;

   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         // Idle level of the pulled-up pin, so no false edge after reset
         pulse_s1_r <= 1'b1;
         pulse_s2_r <= 1'b1;
         sel_s1_r <= fsc_pkg::START_GND;
         sel_s2_r <= fsc_pkg::START_GND;
      end
      else if (ce)
      begin
         pulse_s1_r <= speed_pulse_input;
         pulse_s2_r <= pulse_s1_r;
         sel_s1_r <= startup_select;
         sel_s2_r <= sel_s1_r;
      end
   end

   function automatic logic [8:0] strap_code(input logic [1:0] sel);
      case (sel)
         fsc_pkg::START_OPEN: strap_code = fsc_pkg::DRIVE_OPEN;
         fsc_pkg::START_VCC: strap_code = fsc_pkg::DRIVE_FULL;
         default: strap_code = fsc_pkg::DRIVE_ZERO;
      endcase
   endfunction : strap_code

   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         cfg_r <= 8'h00;
         dyn_r <= fsc_pkg::DYN_RESET;
         tgt_cnt_r <= fsc_pkg::COUNT_FULL;
      end
      else if (ce)
      begin
         if (cfg_we)
            cfg_r <= cfg_wdata;
         if (dyn_we)
            dyn_r <= dyn_wdata;
         if (target_speed_count_we)
            tgt_cnt_r <= target_speed_count_wdata;
      end
   end

   // 8192 Hz measurement tick
   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
         div_r <= '0;
      else if (ce)
         div_r <= (div_r == 32'(MEAS_DIV - 1)) ? '0 : div_r + 32'h1;
   end
   assign tick = ce && div_r == 32'(MEAS_DIV - 1);

   fsc_speed_pulse_input_meter #(.COUNT_W(11)) u_meter (
      .clk(clk),
      .rst_n(srst_n),
      .ce(ce),
      .enable(speed_pulse_input_en | speed_mode),
      .tick(tick),
      .range_code(dyn_r[fsc_pkg::RANGE_MSB:fsc_pkg::RANGE_LSB]),
      .pulse_sync(pulse_s2_r),
      .count(meas),
      .done(meas_done)
   );

   // Target drive: strap at start, host writes, speed loop
   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         tgt_drive_r <= fsc_pkg::DRIVE_ZERO;
         strap_done_r <= 1'b0;
         strap_wait_r <= 2'h0;
      end
      else if (ce)
      begin
         if (!strap_done_r)
         begin
            // Wait until the strap synchroniser holds the pin value
            if (strap_wait_r == 2'h2)
            begin
               tgt_drive_r <= strap_code(sel_s2_r);
               strap_done_r <= 1'b1;
            end
            else
               strap_wait_r <= strap_wait_r + 2'h1;
         end
         else if (drive_we)
            tgt_drive_r <= drive_wdata;
         else if (speed_mode && meas_done)
         begin
            if (meas > tgt_cnt_r && tgt_drive_r != fsc_pkg::DRIVE_FULL)
               tgt_drive_r <= tgt_drive_r + 9'h001;
            else if (meas < tgt_cnt_r && tgt_drive_r != fsc_pkg::DRIVE_ZERO)
               tgt_drive_r <= tgt_drive_r - 9'h001;
         end
      end
   end

   // Step interval doubles per rate code
   assign slew_limit = 32'(RATE_BASE) << dyn_r[fsc_pkg::RATE_MSB:fsc_pkg::RATE_LSB];

   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         drive_r <= fsc_pkg::DRIVE_ZERO;
         slew_r <= '0;
      end
      else if (ce)
      begin
         if (tgt_cnt_r == fsc_pkg::COUNT_FULL)
         begin
            drive_r <= fsc_pkg::DRIVE_ZERO;
            slew_r <= '0;
         end
         else if (!strap_done_r)
            drive_r <= strap_code(sel_s2_r);
         else if (slew_r + 32'h1 >= slew_limit)
         begin
            slew_r <= '0;
            if (drive_r < tgt_drive_r)
               drive_r <= drive_r + 9'h001;
            else if (drive_r > tgt_drive_r)
               drive_r <= drive_r - 9'h001;
         end
         else
            slew_r <= slew_r + 32'h1;
      end
   end

   // Fault when count above target; set wins over clear
   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
         fault_r <= 1'b0;
      else if (ce)
      begin
         if (speed_pulse_input_en && meas_done && meas > tgt_cnt_r)
            fault_r <= 1'b1;
         else if (fault_clr)
            fault_r <= 1'b0;
      end
   end

   assign cfg_q = cfg_r;
   assign dyn_q = dyn_r;
   assign drive_level = drive_r;
   assign target_drive = tgt_drive_r;
   assign measured_count = meas;
   assign fan_fault = fault_r;
endmodule : fsc_channel

// [tb/fsc_channel_chk.sv]
// Checker for the fan speed channel: write capture, slew, speed loop and fault.
// Assumes it is bound into fsc_channel and sees only its ports.
`timescale 1ns/1ps
module fsc_channel_chk #(
   parameter int RATE_BASE = 1,
   parameter int MEAS_DIV = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Host writes
   input wire logic [7:0] cfg_wdata,
   input wire logic cfg_we,
   input wire logic [7:0] dyn_wdata,
   input wire logic dyn_we,
   input wire logic [8:0] drive_wdata,
   input wire logic drive_we,
   input wire logic [10:0] target_speed_count_wdata,
   input wire logic target_speed_count_we,
   input wire logic fault_clr,
   // Outputs
   input wire logic [8:0] drive_level,
   input wire logic [8:0] target_drive,
   input wire logic [7:0] cfg_q,
   input wire logic [7:0] dyn_q,
   input wire logic fan_fault
);
   logic [10:0] tgt_r;
   logic [3:0] age_r;
   logic full;
   assign full = (tgt_r == fsc_pkg::COUNT_FULL);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tgt_r <= fsc_pkg::COUNT_FULL;
      else if (target_speed_count_we && ce)
         tgt_r <= target_speed_count_wdata;
   end
   // Strap capture moves target_drive early on, so loop checks wait
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         age_r <= 4'h0;
      else if (age_r != 4'hF)
         age_r <= age_r + 4'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   cfg_write_a: assert property (ce && cfg_we |=> cfg_q == $past(cfg_wdata))
      else $error("config write lost");
   dyn_write_a: assert property (ce && dyn_we |=> dyn_q == $past(dyn_wdata))
      else $error("dynamics write lost");
   drive_write_a: assert property (ce && drive_we && age_r == 4'hF |=> target_drive == $past(drive_wdata))
      else $error("drive write lost");
   slew_step_a: assert property (!full && !$past(full) && drive_level != $past(drive_level) |->
      (drive_level - $past(drive_level) == 9'h001) || ($past(drive_level) - drive_level == 9'h001))
      else $error("drive moved more than one code");
   full_zero_a: assert property (full |=> drive_level == 9'h000)
      else $error("drive not zero at full count");
   fault_hold_a: assert property (fan_fault && !fault_clr |=> fan_fault)
      else $error("fault dropped");
   fault_cause_a: assert property ($rose(fan_fault) |-> cfg_q[fsc_pkg::CFG_SPEED_PULSE_INPUT_EN_BIT] && !full)
      else $error("fault without cause");
   loop_only_a: assert property (age_r == 4'hF && !$past(drive_we) && target_drive != $past(target_drive) |->
      $past(cfg_q[fsc_pkg::CFG_MODE_BIT]) &&
      ((target_drive - $past(target_drive) == 9'h001) || ($past(target_drive) - target_drive == 9'h001)))
      else $error("bad loop adjust");
endmodule : fsc_channel_chk
bind fsc_channel fsc_channel_chk #(.RATE_BASE(RATE_BASE), .MEAS_DIV(MEAS_DIV)) i_chk (.clk(clk), .rst_n(rst_n),
   .ce(ce), .cfg_wdata(cfg_wdata), .cfg_we(cfg_we), .dyn_wdata(dyn_wdata), .dyn_we(dyn_we),
   .drive_wdata(drive_wdata), .drive_we(drive_we), .target_speed_count_wdata(target_speed_count_wdata),
   .target_speed_count_we(target_speed_count_we), .fault_clr(fault_clr), .drive_level(drive_level),
   .target_drive(target_drive), .cfg_q(cfg_q), .dyn_q(dyn_q), .fan_fault(fan_fault));

// [tb/fsc_fan_model.sv]
// Fan model: speed_pulse_input period shortens as drive rises to 0x118, stalls at zero drive.
// Assumes the speed_pulse_input line idles high through its pull-up when stalled.
`timescale 1ns/1ps
module fsc_fan_model (
   // Clock and drive
   input wire logic clk,
   input wire logic [8:0] drive_level,
   // Speed_pulse_input pin
   output logic speed_pulse_input
);
   int cnt = 0;
   int per;
   initial speed_pulse_input = 1'b1;
   always @(posedge clk)
   begin
      per = (drive_level > 9'h118) ? 20 : 300 - int'(drive_level);
      cnt <= (drive_level == 9'h000 || cnt >= per - 1) ? 0 : cnt + 1;
      speed_pulse_input <= (drive_level == 9'h000) || (cnt < per / 2);
   end
endmodule : fsc_fan_model

// [tb/fan_speed_channel_control_tb.sv]
// Testbench: host write sequences against the channel, fan model on the speed_pulse_input pin.
// Assumes shortened slew base 1 and tick divider 4.
`timescale 1ns/1ps
module fan_speed_channel_control_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] cfg_wdata = 8'h00, dyn_wdata = 8'h00;
   logic cfg_we = 1'b0, dyn_we = 1'b0, drive_we = 1'b0, target_speed_count_we = 1'b0, fault_clr = 1'b0;
   logic [8:0] drive_wdata = 9'h000;
   logic [10:0] target_speed_count_wdata = 11'h000;
   logic speed_pulse_input;
   logic [1:0] strap = 2'h1;
   logic [8:0] drive_level, target_drive, td;
   logic [10:0] measured_count;
   logic [7:0] cfg_q, dyn_q;
   logic fan_fault;
   int n_errors = 0;
   int samples_checked = 0;
   int n;
   always #20 clk = ~clk;
   fsc_channel #(.RATE_BASE(1), .MEAS_DIV(4)) i_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
      .cfg_wdata(cfg_wdata), .cfg_we(cfg_we), .dyn_wdata(dyn_wdata), .dyn_we(dyn_we),
      .drive_wdata(drive_wdata), .drive_we(drive_we), .target_speed_count_wdata(target_speed_count_wdata),
      .target_speed_count_we(target_speed_count_we), .fault_clr(fault_clr),
      .speed_pulse_input(speed_pulse_input), .startup_select(strap), .drive_level(drive_level),
      .target_drive(target_drive), .measured_count(measured_count), .cfg_q(cfg_q), .dyn_q(dyn_q),
      .fan_fault(fan_fault));
   fsc_fan_model i_fan (.clk(clk), .drive_level(drive_level), .speed_pulse_input(speed_pulse_input));
   // Exact match when lo equals hi; unknown never passes
   task chk(input string what, input logic [10:0] seen, input logic [10:0] lo, input logic [10:0] hi);
      samples_checked++;
      if ((seen >= lo && seen <= hi) !== 1'b1)
      begin
         n_errors++;
         $display("MISMATCH %s expected %0h..%0h seen %0h", what, lo, hi, seen);
      end
   endtask : chk
   // sel: 0 cfg, 1 dyn, 2 drive, 3 target count, 4 fault clear
   task wr(input int sel, input logic [10:0] d);
      @(posedge clk);
      cfg_wdata <= d[7:0];
      dyn_wdata <= d[7:0];
      drive_wdata <= d[8:0];
      target_speed_count_wdata <= d;
      {cfg_we, dyn_we, drive_we, target_speed_count_we, fault_clr} <= 5'(1 << (4 - sel));
      @(posedge clk);
      {cfg_we, dyn_we, drive_we, target_speed_count_we, fault_clr} <= 5'h00;
      @(negedge clk);
   endtask : wr
   function automatic logic [10:0] obs(input int sel);
      return (sel == 0) ? {2'h0, drive_level} : (sel == 1) ? measured_count : {10'h000, fan_fault};
   endfunction : obs
   task wt(input int sel, input logic [10:0] v, input int lim);
      n = 0;
      while (obs(sel) !== v && n < lim)
      begin
         @(negedge clk);
         n++;
      end
   endtask : wt
   task final_report;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (80000) @(posedge clk);
      n_errors++;
      final_report();
   end
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(negedge clk);
      chk("target_drive", 11'(target_drive), 11'h180, 11'h180);
      chk("drive_level", 11'(drive_level), 11'h000, 11'h000);
      chk("cfg_q", 11'(cfg_q), 11'h000, 11'h000);
      chk("dyn_q", 11'(dyn_q), 11'h03C, 11'h03C);
      $display("test reset done");
      wr(1, 11'h024);
      wr(2, 11'h010);
      wr(3, 11'h7FE);
      wt(0, 11'h010, 200);
      chk("ramp cycles", 11'(n), 11'h01C, 11'h024);
      chk("drive_level", 11'(drive_level), 11'h010, 11'h010);
      $display("test ramp done");
      wr(0, 11'h040);
      wr(2, 11'h064);
      repeat (3000) @(negedge clk);
      chk("count range 1", measured_count, 11'h063, 11'h065);
      wr(1, 11'h044);
      repeat (4000) @(negedge clk);
      chk("count range 2", measured_count, 11'h0C7, 11'h0C9);
      wr(3, 11'h7FF);
      wt(0, 11'h000, 1000);
      chk("drive at full count", 11'(drive_level), 11'h000, 11'h000);
      wr(3, 11'h7FE);
      $display("test measure done");
      wr(1, 11'h004);
      wr(3, 11'h03C);
      wr(0, 11'h080);
      chk("cfg_q", 11'(cfg_q), 11'h080, 11'h080);
      repeat (20000) @(negedge clk);
      wr(1, 11'h00C);
      repeat (10000) @(negedge clk);
      chk("loop count", measured_count, 11'h03A, 11'h03E);
      chk("loop drive", 11'(target_drive), 11'h037, 11'h040);
      td = target_drive;
      wr(2, 11'(td));
      wr(3, 11'h7FE);
      wr(0, 11'h000);
      td = target_drive;
      repeat (2000) @(negedge clk);
      chk("held drive", 11'(target_drive), 11'(td), 11'(td));
      $display("test speed mode done");
      wr(3, 11'h064);
      wr(0, 11'h040);
      wr(2, 11'h020);
      wt(0, 11'h020, 400);
      chk("step down", 11'(drive_level), 11'h020, 11'h020);
      wr(2, 11'h000);
      wt(2, 11'h001, 20000);
      chk("fan_fault", 11'(fan_fault), 11'h001, 11'h001);
      chk("stalled count", measured_count, 11'h7FF, 11'h7FF);
      wr(0, 11'h000);
      wr(4, 11'h000);
      chk("fault cleared", 11'(fan_fault), 11'h000, 11'h000);
      repeat (10000) @(negedge clk);
      chk("no fault untached", 11'(fan_fault), 11'h000, 11'h000);
      $display("test fault done");
      @(posedge clk);
      strap <= 2'h2;
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(negedge clk);
      chk("strap vcc", 11'(target_drive), 11'h1FF, 11'h1FF);
      chk("cfg after reset", 11'(cfg_q), 11'h000, 11'h000);
      chk("fault after reset", 11'(fan_fault), 11'h000, 11'h000);
      $display("test second reset done");
      final_report();
   end
endmodule : fan_speed_channel_control_tb
